// file: include/asq_pkg.sv
// Constants, types and register map of the acquisition set sequencer
`default_nettype none
package asq_pkg;
  // ***********************
  // Sizes
  // ***********************
  localparam int SLOTS   = 8;
  localparam int SLOT_W  = 3;
  localparam int FEAT_N  = 6;
  localparam int VAL_W   = 16;
  localparam int DW      = 32;
  localparam int AW      = 8;
  localparam int LINES   = 3;
  localparam int SRC_N   = LINES + 1;
  // ***********************
  // Register byte offsets
  // ***********************
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_STAT   = 8'h04;
  localparam logic [7:0] A_FPICK  = 8'h08;
  localparam logic [7:0] A_FON    = 8'h0C;
  localparam logic [7:0] A_SPICK  = 8'h10;
  localparam logic [7:0] A_SCMD   = 8'h14;
  localparam logic [7:0] A_SOK    = 8'h18;
  localparam logic [7:0] A_BPICK  = 8'h1C;
  localparam logic [7:0] A_HSRC   = 8'h20;
  localparam logic [7:0] A_HPOL   = 8'h24;
  localparam logic [7:0] A_FOLLOW = 8'h28;
  localparam logic [7:0] A_FIRST  = 8'h2C;
  localparam logic [7:0] A_FEAT0  = 8'h40;
  localparam logic [7:0] A_FEAT5  = 8'h54;
  localparam logic [7:0] A_IMPL   = 8'h58;
  localparam logic [7:0] A_FIX    = 8'h5C;
  localparam logic [7:0] A_AUTO   = 8'h60;
  // ***********************
  // Field positions
  // ***********************
  localparam int CTRL_RUN    = 0;
  localparam int CTRL_SETUP  = 1;
  localparam int CMD_STORE   = 0;
  localparam int CMD_RECALL  = 1;
  localparam int CMD_ERASE   = 2;
  localparam int STAT_OK     = 0;
  localparam int STAT_RUN    = 1;
  localparam int STAT_CUR    = 4;
  localparam int FI_WIDTH    = 4;
  localparam int FI_HEIGHT   = 5;
  // ***********************
  // Reset values
  // ***********************
  localparam logic [VAL_W-1:0]  RST_VAL  = 16'h0000;
  localparam logic [SLOT_W-1:0] RST_SLOT = 3'h0;
  // ***********************
  // Types
  // ***********************
  typedef enum logic [2:0] {
    F_EXPO, F_GAIN, F_OFFX, F_OFFY, F_WIDTH, F_HEIGHT
  } asq_feat_t;
  typedef enum logic [1:0] {
    SRC_FRAME, SRC_LINE0, SRC_LINE1, SRC_LINE2
  } asq_src_t;
  typedef enum logic {
    POL_RISE, POL_FALL
  } asq_pol_t;
  typedef struct packed {
    asq_src_t            src;
    asq_pol_t            pol;
    logic [SLOT_W-1:0]   next;
  } asq_path_t;
  typedef struct packed {
    logic [VAL_W-1:0]              impl;
    logic [FEAT_N-1:0][VAL_W-1:0]  feat;
  } asq_rec_t;
  typedef struct packed {
    logic [FEAT_N-1:0][VAL_W-1:0]  feat;
    logic [VAL_W-1:0]              impl;
    logic [VAL_W-1:0]              fix;
    logic                          auto_on;
  } asq_live_t;
endpackage : asq_pkg
`default_nettype wire

// file: core/asq_slot_mem.sv
// Slot record memory with registered read data
`default_nettype none
module asq_slot_mem #(
  parameter int DEPTH = 8,
  parameter int AW    = 3,
  parameter int W     = 112
) (
  // Clock and reset
  input  wire logic          mclk_i,
  input  wire logic          nrst_i,
  // Write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [W-1:0]  wdata_i,
  // Read port
  input  wire logic          re_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [W-1:0]  rdata_o
);
  logic [W-1:0] mem_q [DEPTH];

  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= '0;
    end else if (re_i) begin
      rdata_o <= mem_q[raddr_i];
    end
  end
endmodule : asq_slot_mem
`default_nettype wire

// file: core/asq_core.sv
// Acquisition set sequencer with Wishbone register access
`default_nettype none
module asq_core (
  // Clock and reset
  input  wire logic                    mclk_i,
  input  wire logic                    nrst_i,
  // Wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [asq_pkg::AW-1:0]  wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [asq_pkg::DW-1:0]  wb_dat_i,
  output logic      [asq_pkg::DW-1:0]  wb_dat_o,
  output logic                         wb_ack_o,
  // Trigger pins and camera state
  input  wire logic                    frame_begin_event_i,
  input  wire logic [asq_pkg::LINES-1:0] trig_line_i,
  input  wire logic                    streaming_i,
  // Live configuration
  output var asq_pkg::asq_live_t       live_o,
  output logic [asq_pkg::SLOT_W-1:0]   current_slot_o,
  output logic                         running_o
);
  localparam int SW = asq_pkg::SLOT_W;
  localparam int VW = asq_pkg::VAL_W;
  localparam int NF = asq_pkg::FEAT_N;
  localparam int NS = asq_pkg::SLOTS;
  localparam int RW = $bits(asq_pkg::asq_rec_t);

  // ***********************
  // State
  // ***********************
  logic                 ack_q;
  logic [31:0]          dat_q;
  logic                 run_q;
  logic                 setup_q;
  logic                 setup_ok_q;
  logic [2:0]           fpick_q;
  logic [NF-1:0]        mask_q;
  logic [SW-1:0]        spick_q;
  logic [SW-1:0]        first_q;
  logic [SW-1:0]        cur_q;
  logic [NF-1:0][VW-1:0] feat_q;
  logic [VW-1:0]        impl_q;
  logic [VW-1:0]        fix_q;
  logic                 auto_q;
  logic                 auto_eff_q;
  logic [NS-1:0]        saved_q;
  logic [NS-1:0]        legal_q;
  logic [VW-1:0]        slot_fix_q  [NS];
  logic [NF-1:0]        slot_mask_q [NS];
  asq_pkg::asq_path_t   path_q      [NS];
  logic                 ld_req_q;
  logic [SW-1:0]        ld_addr_q;
  logic                 ld_v_q;
  logic [asq_pkg::SRC_N-1:0] pin_s1_q;
  logic [asq_pkg::SRC_N-1:0] pin_s2_q;
  logic [asq_pkg::SRC_N-1:0] pin_s3_q;

  // ***********************
  // Bus decode
  // ***********************
  wire        hit     = wb_cyc_i & wb_stb_i;
  wire        wr_fire = hit & wb_we_i & ack_q;
  wire [31:0] bmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                         {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire is_ctrl   = wb_adr_i == asq_pkg::A_CTRL;
  wire is_fpick  = wb_adr_i == asq_pkg::A_FPICK;
  wire is_fon    = wb_adr_i == asq_pkg::A_FON;
  wire is_spick  = wb_adr_i == asq_pkg::A_SPICK;
  wire is_scmd   = wb_adr_i == asq_pkg::A_SCMD;
  wire is_bpick  = wb_adr_i == asq_pkg::A_BPICK;
  wire is_hsrc   = wb_adr_i == asq_pkg::A_HSRC;
  wire is_hpol   = wb_adr_i == asq_pkg::A_HPOL;
  wire is_follow = wb_adr_i == asq_pkg::A_FOLLOW;
  wire is_first  = wb_adr_i == asq_pkg::A_FIRST;
  wire is_impl   = wb_adr_i == asq_pkg::A_IMPL;
  wire is_fix    = wb_adr_i == asq_pkg::A_FIX;
  wire is_auto   = wb_adr_i == asq_pkg::A_AUTO;
  wire is_feat   = (wb_adr_i >= asq_pkg::A_FEAT0) &&
                   (wb_adr_i <= asq_pkg::A_FEAT5) &&
                   (wb_adr_i[1:0] == 2'h0);
  wire [7:0] feat_off = wb_adr_i - asq_pkg::A_FEAT0;
  wire [2:0] feat_idx = feat_off[4:2];

  // ***********************
  // Slot checks
  // ***********************
  logic [NS-1:0] slot_ok;
  asq_pkg::asq_path_t pick_path;
  asq_pkg::asq_path_t cur_path;
  assign pick_path = path_q[spick_q];
  assign cur_path  = path_q[cur_q];

  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_ok
      assign slot_ok[gi] = saved_q[gi] & legal_q[gi] &
                           (slot_fix_q[gi] == fix_q) &
                           (slot_mask_q[gi] == mask_q);
    end
  endgenerate

  logic chain_ok;
  always_comb begin
    chain_ok = slot_ok[first_q] & (|mask_q);
    for (int i = 0; i < NS; i++) begin
      if (slot_ok[i] && !slot_ok[path_q[i].next]) begin
        chain_ok = 1'b0;
      end
    end
  end

  // ***********************
  // Read mux
  // ***********************
  wire [31:0] stat_val = {25'h0, cur_q, 2'h0, run_q, setup_ok_q};
  wire [31:0] rd_val =
    is_ctrl   ? {30'h0, setup_q, run_q} :
    (wb_adr_i == asq_pkg::A_STAT) ? stat_val :
    is_fpick  ? {29'h0, fpick_q} :
    is_fon    ? {31'h0, mask_q[fpick_q]} :
    is_spick  ? {29'h0, spick_q} :
    (wb_adr_i == asq_pkg::A_SOK) ? {31'h0, slot_ok[spick_q]} :
    is_hsrc   ? {30'h0, pick_path.src} :
    is_hpol   ? {31'h0, pick_path.pol} :
    is_follow ? {29'h0, pick_path.next} :
    is_first  ? {29'h0, first_q} :
    is_feat   ? {16'h0, feat_q[feat_idx]} :
    is_impl   ? {16'h0, impl_q} :
    is_fix    ? {16'h0, fix_q} :
    is_auto   ? {31'h0, auto_q} :
    32'h0;
  wire [31:0] wv = (rd_val & ~bmask) | (wb_dat_i & bmask);

  wire slot_in_range = wv[31:SW] == '0;
  wire [SW-1:0] wv_slot = wv[SW-1:0];

  // ***********************
  // Write strobes
  // ***********************
  // feature enables only outside setup and run, first slot only outside run, picks any time
  wire w_mask   = wr_fire & is_fon & ~setup_q & ~run_q;
  wire w_fpick  = wr_fire & is_fpick & (wv < 32'(NF));
  wire w_spick  = wr_fire & is_spick & slot_in_range;
  wire w_first  = wr_fire & is_first & slot_in_range & ~run_q;
  wire bpick_ok = wr_fire & is_bpick & (wv == 32'h0);
  wire w_hsrc   = wr_fire & is_hsrc & ~run_q;
  wire w_hpol   = wr_fire & is_hpol & ~run_q;
  wire w_follow = wr_fire & is_follow & slot_in_range & ~run_q;
  wire w_impl   = wr_fire & is_impl & ~run_q;
  wire w_fix    = wr_fire & is_fix & ~setup_q & ~run_q;
  wire w_auto   = wr_fire & is_auto;
  wire w_feat   = wr_fire & is_feat & ~(run_q & mask_q[feat_idx]);
  wire w_ctrl   = wr_fire & is_ctrl;
  wire cmd_fire = wr_fire & is_scmd;
  wire do_store  = cmd_fire & wv[asq_pkg::CMD_STORE] & setup_q & ~run_q;
  wire do_recall = cmd_fire & wv[asq_pkg::CMD_RECALL] & slot_ok[spick_q];
  wire do_erase  = cmd_fire & wv[asq_pkg::CMD_ERASE] & ~run_q;
  wire setup_on  = w_ctrl & wv[asq_pkg::CTRL_SETUP] & ~run_q & ~setup_q;
  wire setup_off = w_ctrl & ~wv[asq_pkg::CTRL_SETUP] & setup_q;
  wire run_on    = w_ctrl & wv[asq_pkg::CTRL_RUN] & ~run_q & setup_ok_q &
                   ~setup_q & ~streaming_i;
  wire run_off   = w_ctrl & ~wv[asq_pkg::CTRL_RUN] & run_q;

  // ***********************
  // Trigger select
  // ***********************
  wire src_now  = pin_s2_q[cur_path.src];
  wire src_prev = pin_s3_q[cur_path.src];
  wire hop_edge = (cur_path.pol == asq_pkg::POL_RISE) ?
                  (src_now & ~src_prev) : (~src_now & src_prev);
  wire hop      = run_q & ~run_off & hop_edge & ~ld_req_q;

  // ***********************
  // Slot memory
  // ***********************
  asq_pkg::asq_rec_t wr_rec;
  asq_pkg::asq_rec_t rd_rec;
  logic [RW-1:0]     rd_bits;
  assign wr_rec.impl = impl_q;
  assign wr_rec.feat = feat_q;
  assign rd_rec      = rd_bits;

  asq_slot_mem #(
    .DEPTH (NS),
    .AW    (SW),
    .W     (RW)
  ) u_mem (
    .mclk_i  (mclk_i),
    .nrst_i  (nrst_i),
    .we_i    (do_store),
    .waddr_i (spick_q),
    .wdata_i (wr_rec),
    .re_i    (ld_req_q),
    .raddr_i (ld_addr_q),
    .rdata_o (rd_bits)
  );

  // ***********************
  // Bus answer
  // ***********************
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= hit & ~ack_q;
      if (hit && !ack_q) begin
        dat_q <= rd_val;
      end
    end
  end

  // ***********************
  // Pin synchronisers
  // ***********************
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
    end else begin
      pin_s1_q <= {trig_line_i, frame_begin_event_i};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // ***********************
  // Mode control
  // ***********************
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      setup_q    <= 1'b0;
      setup_ok_q <= 1'b0;
      run_q      <= 1'b0;
      cur_q      <= asq_pkg::RST_SLOT;
      ld_req_q   <= 1'b0;
      ld_addr_q  <= asq_pkg::RST_SLOT;
      ld_v_q     <= 1'b0;
      auto_eff_q <= 1'b0;
    end else begin
      ld_v_q   <= ld_req_q;
      ld_req_q <= 1'b0;
      if (setup_on) begin
        setup_q    <= 1'b1;
        setup_ok_q <= 1'b0;
      end else if (setup_off) begin
        setup_q    <= 1'b0;
        setup_ok_q <= chain_ok;
      end
      if (run_off) begin
        run_q <= 1'b0;
      end else if (run_on) begin
        run_q     <= 1'b1;
        cur_q     <= first_q;
        ld_req_q  <= 1'b1;
        ld_addr_q <= first_q;
      end else if (hop) begin
        cur_q     <= cur_path.next;
        ld_req_q  <= 1'b1;
        ld_addr_q <= cur_path.next;
      end else if (do_recall) begin
        ld_req_q  <= 1'b1;
        ld_addr_q <= spick_q;
      end
      auto_eff_q <= auto_q & ~(run_q | run_on);
    end
  end

  // ***********************
  // Selection registers
  // ***********************
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fpick_q <= 3'h0;
      mask_q  <= '0;
      spick_q <= asq_pkg::RST_SLOT;
      first_q <= asq_pkg::RST_SLOT;
      auto_q  <= 1'b0;
    end else begin
      if (w_fpick) begin
        fpick_q <= wv[2:0];
      end
      if (w_mask) begin
        mask_q[fpick_q] <= wv[0];
      end
      if (w_spick) begin
        spick_q <= wv_slot;
      end
      if (w_first) begin
        first_q <= wv_slot;
      end
      if (w_auto) begin
        auto_q <= wv[0];
      end
    end
  end

  // ***********************
  // Branch table
  // ***********************
  // source, polarity, following slot
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < NS; i++) begin
        path_q[i] <= '0;
      end
    end else begin
      if (w_hsrc) begin
        path_q[spick_q].src <= asq_pkg::asq_src_t'(wv[1:0]);
      end
      if (w_hpol) begin
        path_q[spick_q].pol <= asq_pkg::asq_pol_t'(wv[0]);
      end
      if (w_follow) begin
        path_q[spick_q].next <= wv_slot;
      end
    end
  end

  // ***********************
  // Slot bookkeeping
  // ***********************
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      saved_q <= '0;
      legal_q <= '0;
      for (int i = 0; i < NS; i++) begin
        slot_fix_q[i]  <= asq_pkg::RST_VAL;
        slot_mask_q[i] <= '0;
      end
    end else begin
      if (do_erase) begin
        saved_q <= '0;
      end else if (do_store) begin
        saved_q[spick_q]     <= 1'b1;
        legal_q[spick_q]     <= (feat_q[asq_pkg::FI_WIDTH] != '0) &&
                                (feat_q[asq_pkg::FI_HEIGHT] != '0);
        slot_fix_q[spick_q]  <= fix_q;
        slot_mask_q[spick_q] <= mask_q;
      end
    end
  end

  // ***********************
  // Live configuration
  // ***********************
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      feat_q <= '0;
      impl_q <= asq_pkg::RST_VAL;
      fix_q  <= asq_pkg::RST_VAL;
    end else begin
      if (ld_v_q) begin
        for (int i = 0; i < NF; i++) begin
          if (mask_q[i]) begin
            feat_q[i] <= rd_rec.feat[i];
          end
        end
        impl_q <= rd_rec.impl;
      end else begin
        if (w_feat) begin
          feat_q[feat_idx] <= wv[VW-1:0];
        end
        if (w_impl) begin
          impl_q <= wv[VW-1:0];
        end
      end
      if (w_fix) begin
        fix_q <= wv[VW-1:0];
      end
    end
  end

  // ***********************
  // Outputs
  // ***********************
  assign wb_ack_o       = ack_q;
  assign wb_dat_o       = dat_q;
  assign live_o.feat    = feat_q;
  assign live_o.impl    = impl_q;
  assign live_o.fix     = fix_q;
  assign live_o.auto_on = auto_eff_q;
  assign current_slot_o = cur_q;
  assign running_o      = run_q;
endmodule : asq_core
`default_nettype wire

// file: verification/asq_core_properties.sv
// Port checker for the acquisition set sequencer
`default_nettype none
module asq_core_chk (
  // Clock and reset
  input wire logic               mclk_i,
  input wire logic               nrst_i,
  // Wishbone slave
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_we_i,
  input wire logic [7:0]         wb_adr_i,
  input wire logic [3:0]         wb_sel_i,
  input wire logic [31:0]        wb_dat_i,
  input wire logic [31:0]        wb_dat_o,
  input wire logic               wb_ack_o,
  // Pins and state
  input wire logic               frame_begin_event_i,
  input wire logic [2:0]         trig_line_i,
  input wire logic               streaming_i,
  input wire asq_pkg::asq_live_t live_o,
  input wire logic [2:0]         current_slot_o,
  input wire logic               running_o
);
  // ****************
  // Properties
  // ****************
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  wire req_w = wb_cyc_i && wb_stb_i;
  wire fixw_w = wb_ack_o && wb_we_i && wb_adr_i == asq_pkg::A_FIX && !running_o;
  AST_ACK_LAT: assert property (req_w && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_ACK_CAUSE: assert property (!req_w |=> !wb_ack_o) else $error("ack without request");
  AST_UNMAP_RD: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'hFC |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_RUN_START: assert property ($rose(running_o) |-> $past(wb_ack_o && wb_we_i && wb_dat_i[0]
    && wb_adr_i == asq_pkg::A_CTRL && !streaming_i)) else $error("run start without cause");
  AST_AUTO_OFF: assert property (running_o && $past(running_o) |-> !live_o.auto_on)
    else $error("auto on while running");
  AST_SLOT_MOVE: assert property ($changed(current_slot_o) |-> running_o)
    else $error("slot moved while idle");
  AST_FIX_LOCK: assert property ($changed(live_o.fix) |-> $past(fixw_w) || $past(fixw_w, 2))
    else $error("fixed value changed");
  AST_RUN_STOP: assert property ($fell(running_o) |-> $stable(current_slot_o))
    else $error("slot changed at stop");
endmodule : asq_core_chk
bind asq_core asq_core_chk u_chk (.mclk_i(mclk_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .live_o(live_o),
  .frame_begin_event_i(frame_begin_event_i), .trig_line_i(trig_line_i),
  .streaming_i(streaming_i), .current_slot_o(current_slot_o), .running_o(running_o));
`default_nettype wire

// file: verification/asq_trig_model.sv
// Trigger pin model for frame and line events
`default_nettype none
module asq_trig_model (
  // Clock
  input  wire logic       mclk_i,
  // Bench command
  input  wire logic       fire_i,
  input  wire logic [1:0] src_i,
  // Trigger pins
  output logic            frame_begin_event_o,
  output logic [2:0]      trig_line_o
);
  logic [2:0] hold_q = 3'h0;
  logic [1:0] src_q = 2'h0;
  logic [3:0] sel_w;
  always_ff @(posedge mclk_i) begin
    if (fire_i) begin
      hold_q <= 3'h4;
      src_q  <= src_i;
    end else if (hold_q != 3'h0) begin
      hold_q <= hold_q - 3'h1;
    end
  end
  assign sel_w = (hold_q != 3'h0) ? (4'h1 << src_q) : 4'h0;
  assign frame_begin_event_o = sel_w[0];
  assign trig_line_o = sel_w[3:1];
endmodule : asq_trig_model
`default_nettype wire

// file: verification/tb_acquisition_set_sequencer.sv
// Self-checking bench for the acquisition set sequencer
`default_nettype none
module tb_acquisition_set_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic               mclk_i, nrst_i = 0, cyc = 0, stb = 0, we = 0, fire = 0, strm = 0;
  logic [7:0]         adr = 8'h00;
  logic [3:0]         sel = 4'h0;
  logic [31:0]        wdat = 32'h0, rdat, dato;
  logic [1:0]         src = 2'h0;
  logic [2:0]         tl, cur;
  logic               fbe, ack, run;
  asq_pkg::asq_live_t live;
  int                 mismatches = 0;
  int                 total_checks = 0;
  asq_core uut (.mclk_i(mclk_i), .nrst_i(nrst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack),
    .frame_begin_event_i(fbe), .trig_line_i(tl), .streaming_i(strm), .live_o(live),
    .current_slot_o(cur), .running_o(run));
  asq_trig_model u_trig (.mclk_i(mclk_i), .fire_i(fire), .src_i(src), .frame_begin_event_o(fbe),
    .trig_line_o(tl));
  // ****************
  // Helpers
  // ****************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : tick
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge mclk_i);
      n++;
    end while (ack !== 1'b1);
    chk("ack latency", n, 2);
    rdat = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(0, a, 0);
    chk(what, rdat, exp);
  endtask : rdchk
  task automatic pulse(input logic [1:0] s);
    fire <= 1'b1;
    src <= s;
    tick(1);
    fire <= 1'b0;
    tick(12);
  endtask : pulse
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset;
    chk("running", run, 0);
    rdchk("status", asq_pkg::A_STAT, 0);
    rdchk("slot ok", asq_pkg::A_SOK, 0);
    rdchk("unmapped", 8'hFC, 0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_setup;
    // pick all six, enable expo, width, height
    for (int f = 0; f < 6; f++) begin
      bus(1, asq_pkg::A_FPICK, f);
      bus(1, asq_pkg::A_FON, f == 0 || f >= 4);
    end
    bus(1, asq_pkg::A_FIX, 32'h0055);
    bus(1, asq_pkg::A_AUTO, 1);
    bus(1, asq_pkg::A_CTRL, 32'h2);
    bus(1, asq_pkg::A_FIX, 32'h00AA);
    tick(1);
    chk("fix lock", live.fix, 32'h0055);
    bus(1, asq_pkg::A_IMPL, 32'h0011);
    bus(1, asq_pkg::A_SPICK, 7);
    bus(1, asq_pkg::A_SPICK, 9);
    rdchk("slot pick", asq_pkg::A_SPICK, 7);
    bus(1, asq_pkg::A_FIRST, 5);
    bus(1, asq_pkg::A_FIRST, 8);
    rdchk("first", asq_pkg::A_FIRST, 5);
    bus(1, asq_pkg::A_FIRST, 0);
    for (int s = 0; s < 3; s++) begin
      bus(1, asq_pkg::A_SPICK, s);
      bus(1, asq_pkg::A_FEAT0, s == 1 ? 32'h07D0 : 32'h0FA0);
      bus(1, asq_pkg::A_FEAT0 + 8'h10, s == 1 ? 32'h0200 : 32'h0400);
      bus(1, asq_pkg::A_FEAT5, s == 2 ? 32'h0 : 32'h0100);
      bus(1, asq_pkg::A_HSRC, s);
      bus(1, asq_pkg::A_HPOL, s == 1);
      bus(1, asq_pkg::A_FOLLOW, 1 - s);
      bus(1, asq_pkg::A_SCMD, 1);
      rdchk("slot ok", asq_pkg::A_SOK, s != 2);
    end
    bus(1, asq_pkg::A_CTRL, 0);
    rdchk("setup ok", asq_pkg::A_STAT, 1);
    $display("test setup done");
  endtask : t_setup
  task automatic t_run;
    strm <= 1'b1;
    bus(1, asq_pkg::A_CTRL, 1);
    tick(3);
    chk("run refused", run, 0);
    strm <= 1'b0;
    bus(1, asq_pkg::A_CTRL, 1);
    tick(4);
    chk("running", run, 1);
    chk("expo", live.feat[0], 32'h0FA0);
    chk("auto", live.auto_on, 0);
    bus(1, asq_pkg::A_FEAT0, 32'h1234);
    bus(1, asq_pkg::A_FEAT0 + 8'h4, 32'h0033);
    bus(1, asq_pkg::A_IMPL, 32'h0077);
    tick(2);
    chk("expo lock", live.feat[0], 32'h0FA0);
    chk("gain", live.feat[1], 32'h0033);
    chk("impl lock", live.impl, 32'h0011);
    pulse(0);
    chk("cur", cur, 1);
    chk("width", live.feat[4], 32'h0200);
    pulse(1);
    chk("cur", cur, 0);
    pulse(1);
    chk("cur other src", cur, 0);
    bus(1, asq_pkg::A_CTRL, 0);
    tick(4);
    chk("stopped", run, 0);
    chk("expo kept", live.feat[0], 32'h0FA0);
    chk("height kept", live.feat[5], 32'h0100);
    chk("auto back", live.auto_on, 1);
    $display("test run done");
  endtask : t_run
  task automatic t_recall;
    bus(1, asq_pkg::A_SPICK, 1);
    bus(1, asq_pkg::A_SCMD, 2);
    tick(4);
    chk("recall", live.feat[0], 32'h07D0);
    bus(1, asq_pkg::A_SPICK, 2);
    bus(1, asq_pkg::A_SCMD, 2);
    tick(4);
    chk("bad recall", live.feat[4], 32'h0200);
    bus(1, asq_pkg::A_SCMD, 4);
    bus(1, asq_pkg::A_SPICK, 0);
    rdchk("erased", asq_pkg::A_SOK, 0);
    $display("test recall done");
  endtask : t_recall
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  initial begin
    #400000;
    mismatches++;
    final_report;
  end
  initial begin
    repeat (16) @(posedge mclk_i);
    nrst_i <= 1'b1;
    t_reset;
    t_setup;
    t_run;
    t_recall;
    final_report;
  end
endmodule : tb_acquisition_set_sequencer
`default_nettype wire
